// file: rtl/dmod_pkg.sv
// Package for the data-move opcode decoder: opcode values, lengths and cycle counts
package dmod_pkg;

    // Operand form of a decoded data-move instruction
    typedef enum logic [4:0] {
        DMOD_NONE,
        DMOD_A_TO_WR,
        DMOD_DIR_TO_WR,
        DMOD_IMM_TO_WR,
        DMOD_A_TO_DIR,
        DMOD_WR_TO_DIR,
        DMOD_DIR_TO_DIR,
        DMOD_IND_TO_DIR,
        DMOD_IMM_TO_DIR,
        DMOD_A_TO_IND,
        DMOD_DIR_TO_IND,
        DMOD_IMM_TO_IND,
        DMOD_IMM_TO_DP,
        DMOD_CODE_DP,
        DMOD_CODE_PC,
        DMOD_XRD_IND,
        DMOD_XRD_DP,
        DMOD_IND_TO_A,
        DMOD_XWR_DP
    } dmod_form_t;

    // Opcode bases; register forms mask the low 3 bits, indirect forms the low bit
    localparam logic [7:0] OP_A_TO_WR    = 8'hF8;
    localparam logic [7:0] OP_DIR_TO_WR  = 8'hA8;
    localparam logic [7:0] OP_IMM_TO_WR  = 8'h78;
    localparam logic [7:0] OP_A_TO_DIR   = 8'hF5;
    localparam logic [7:0] OP_WR_TO_DIR  = 8'h88;
    localparam logic [7:0] OP_DIR_TO_DIR = 8'h85;
    localparam logic [7:0] OP_IND_TO_DIR = 8'h86;
    localparam logic [7:0] OP_IMM_TO_DIR = 8'h75;
    localparam logic [7:0] OP_A_TO_IND   = 8'hF6;
    localparam logic [7:0] OP_DIR_TO_IND = 8'hA6;
    localparam logic [7:0] OP_IMM_TO_IND = 8'h76;
    localparam logic [7:0] OP_IMM_TO_DP  = 8'h90;
    localparam logic [7:0] OP_CODE_DP    = 8'h93;
    localparam logic [7:0] OP_CODE_PC    = 8'h83;
    localparam logic [7:0] OP_XRD_IND    = 8'hE2;
    localparam logic [7:0] OP_XRD_DP     = 8'hE0;
    localparam logic [7:0] OP_IND_TO_A   = 8'hE6;
    localparam logic [7:0] OP_XWR_DP     = 8'hF0;

    localparam logic [7:0] MASK_WR  = 8'hF8;
    localparam logic [7:0] MASK_IND = 8'hFE;

    // Lengths in bytes and fixed cycle counts
    localparam logic [1:0] LEN_1 = 2'h1;
    localparam logic [1:0] LEN_2 = 2'h2;
    localparam logic [1:0] LEN_3 = 2'h3;
    localparam logic [3:0] CYC_1 = 4'h1;
    localparam logic [3:0] CYC_2 = 4'h2;
    localparam logic [3:0] CYC_3 = 4'h3;
    // External access bounds
    localparam logic [3:0] CYC_X_MIN = 4'h2;
    localparam logic [3:0] CYC_X_MAX = 4'h9;

endpackage : dmod_pkg

// file: rtl/dmod_match.sv
// Combinational opcode classifier for the data-move group
`timescale 1ns/1ps
module dmod_match
(
    // Opcode
    input  wire logic [7:0]        opcode,
    // Classification
    output dmod_pkg::dmod_form_t   form,
    output logic       [1:0]       length,
    output logic       [3:0]       cycles,
    output logic                   ext_access
);

    ////////////////////////////////////////////////////////////////////////////
    wire logic is_wr_a   = (opcode & dmod_pkg::MASK_WR) == dmod_pkg::OP_A_TO_WR;   // see RULE_01
    wire logic is_wr_dir = (opcode & dmod_pkg::MASK_WR) == dmod_pkg::OP_DIR_TO_WR; // see RULE_01
    wire logic is_wr_imm = (opcode & dmod_pkg::MASK_WR) == dmod_pkg::OP_IMM_TO_WR; // see RULE_01
    wire logic is_dir_wr = (opcode & dmod_pkg::MASK_WR) == dmod_pkg::OP_WR_TO_DIR; // see RULE_03
    wire logic is_dir_in = (opcode & dmod_pkg::MASK_IND) == dmod_pkg::OP_IND_TO_DIR; // see RULE_05
    wire logic is_in_a   = (opcode & dmod_pkg::MASK_IND) == dmod_pkg::OP_A_TO_IND;  // see RULE_07
    wire logic is_in_dir = (opcode & dmod_pkg::MASK_IND) == dmod_pkg::OP_DIR_TO_IND; // see RULE_08
    wire logic is_in_imm = (opcode & dmod_pkg::MASK_IND) == dmod_pkg::OP_IMM_TO_IND; // see RULE_09
    wire logic is_xrd_in = (opcode & dmod_pkg::MASK_IND) == dmod_pkg::OP_XRD_IND;   // see RULE_13
    wire logic is_a_in   = (opcode & dmod_pkg::MASK_IND) == dmod_pkg::OP_IND_TO_A;  // see RULE_15

    // Masked groups never overlap the exact opcodes, so order is free
    always_comb
    begin
        form       = dmod_pkg::DMOD_NONE;
        length     = dmod_pkg::LEN_1;
        cycles     = dmod_pkg::CYC_1;
        ext_access = 1'b0;
        if (is_wr_a)
        begin
            form = dmod_pkg::DMOD_A_TO_WR; // see RULE_01
        end
        else if (is_wr_dir)
        begin
            form   = dmod_pkg::DMOD_DIR_TO_WR; // see RULE_01
            length = dmod_pkg::LEN_2;
            cycles = dmod_pkg::CYC_2;
        end
        else if (is_wr_imm)
        begin
            form   = dmod_pkg::DMOD_IMM_TO_WR; // see RULE_01
            length = dmod_pkg::LEN_2;
            cycles = dmod_pkg::CYC_2;
        end
        else if (opcode == dmod_pkg::OP_A_TO_DIR)
        begin
            form   = dmod_pkg::DMOD_A_TO_DIR; // see RULE_02
            length = dmod_pkg::LEN_2;
            cycles = dmod_pkg::CYC_2;
        end
        else if (is_dir_wr)
        begin
            form   = dmod_pkg::DMOD_WR_TO_DIR; // see RULE_03
            length = dmod_pkg::LEN_2;
            cycles = dmod_pkg::CYC_2;
        end
        else if (opcode == dmod_pkg::OP_DIR_TO_DIR)
        begin
            form   = dmod_pkg::DMOD_DIR_TO_DIR; // see RULE_04
            length = dmod_pkg::LEN_3;
            cycles = dmod_pkg::CYC_3;
        end
        else if (is_dir_in)
        begin
            form   = dmod_pkg::DMOD_IND_TO_DIR; // see RULE_05
            length = dmod_pkg::LEN_2;
            cycles = dmod_pkg::CYC_2;
        end
        else if (opcode == dmod_pkg::OP_IMM_TO_DIR)
        begin
            form   = dmod_pkg::DMOD_IMM_TO_DIR; // see RULE_06
            length = dmod_pkg::LEN_3;
            cycles = dmod_pkg::CYC_3;
        end
        else if (is_in_a)
        begin
            form = dmod_pkg::DMOD_A_TO_IND; // see RULE_07
        end
        else if (is_in_dir)
        begin
            form   = dmod_pkg::DMOD_DIR_TO_IND; // see RULE_08
            length = dmod_pkg::LEN_2;
            cycles = dmod_pkg::CYC_2;
        end
        else if (is_in_imm)
        begin
            form   = dmod_pkg::DMOD_IMM_TO_IND; // see RULE_09
            length = dmod_pkg::LEN_2;
            cycles = dmod_pkg::CYC_2;
        end
        else if (opcode == dmod_pkg::OP_IMM_TO_DP)
        begin
            form   = dmod_pkg::DMOD_IMM_TO_DP; // see RULE_10
            length = dmod_pkg::LEN_3;
            cycles = dmod_pkg::CYC_3;
        end
        else if (opcode == dmod_pkg::OP_CODE_DP)
        begin
            form   = dmod_pkg::DMOD_CODE_DP; // see RULE_11
            cycles = dmod_pkg::CYC_3;
        end
        else if (opcode == dmod_pkg::OP_CODE_PC)
        begin
            form   = dmod_pkg::DMOD_CODE_PC; // see RULE_12
            cycles = dmod_pkg::CYC_3;
        end
        else if (is_xrd_in)
        begin
            form       = dmod_pkg::DMOD_XRD_IND; // see RULE_13
            cycles     = dmod_pkg::CYC_X_MIN;
            ext_access = 1'b1;
        end
        else if (opcode == dmod_pkg::OP_XRD_DP)
        begin
            form       = dmod_pkg::DMOD_XRD_DP; // see RULE_14
            cycles     = dmod_pkg::CYC_X_MIN;
            ext_access = 1'b1;
        end
        else if (is_a_in)
        begin
            form = dmod_pkg::DMOD_IND_TO_A; // see RULE_15
        end
        else if (opcode == dmod_pkg::OP_XWR_DP)
        begin
            form       = dmod_pkg::DMOD_XWR_DP; // see RULE_17
            cycles     = dmod_pkg::CYC_X_MIN;
            ext_access = 1'b1;
        end
    end

endmodule : dmod_match

// file: rtl/dmod_decoder.sv
// Data-move opcode decoder: registered decode of one opcode per request
// Functional notes
// RULE_01 - F8-FF, A8-AF, 78-7F register load forms
// RULE_02 - F5 stores accumulator to direct, 2/2
// RULE_03 - 88-8F copies register to direct, 2/2
// RULE_04 - 85 direct to direct, 3/3
// RULE_05 - 86-87 indirect memory to direct, 2/2
// RULE_06 - 75 immediate to direct, 3/3
// RULE_07 - F6-F7 accumulator to indirect memory, 1/1
// RULE_08 - A6-A7 direct to indirect memory, 2/2
// RULE_09 - 76-77 immediate to indirect memory, 2/2
// RULE_10 - 90 loads 16-bit data pointer, 3/3
// RULE_11 - 93 code read via data pointer, 1/3
// RULE_12 - 83 code read via program counter, 1/3
// RULE_13 - E2-E3 external read, 8-bit address, 2-9
// RULE_14 - E0 external read via data pointer, 2-9
// RULE_15 - E6-E7 indirect memory to accumulator, 1/1
// RULE_16 - Register from low three, indirect from bit0
// RULE_17 - F0 external write via data pointer, 2-9
`timescale 1ns/1ps
module dmod_decoder
(
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              resetn,
    // Request from fetch
    input  wire logic              op_valid,
    input  wire logic [7:0]        opcode,
    // Decoded result to datapath
    output logic                   dec_valid,
    output logic                   dec_hit,
    output dmod_pkg::dmod_form_t   dec_form,
    output logic       [1:0]       dec_length,
    output logic       [3:0]       dec_cycles_min,
    output logic       [3:0]       dec_cycles_max,
    output logic                   dec_external,
    output logic                   dec_uses_wr,
    output logic       [2:0]       dec_work_reg,
    output logic                   dec_uses_ind,
    output logic                   dec_ind_reg
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset release through two flops
    logic rst_s1_r;
    logic rst_s2_r;

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end
        else
        begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end

    wire logic rst_n = rst_s2_r;

    ////////////////////////////////////////////////////////////////////////////
    // Classification
    dmod_pkg::dmod_form_t m_form;
    logic [1:0]           m_len;
    logic [3:0]           m_cyc;
    logic                 m_ext;

    dmod_match u_match
    (
        .opcode     (opcode),
        .form       (m_form),
        .length     (m_len),
        .cycles     (m_cyc),
        .ext_access (m_ext)
    );

    wire logic hit_nxt = m_form != dmod_pkg::DMOD_NONE;
    // External accesses stretch by wait states, so only a range is known
    wire logic [3:0] cmax_nxt = m_ext ? dmod_pkg::CYC_X_MAX : m_cyc; // see RULE_13
    wire logic uses_wr_nxt = m_form == dmod_pkg::DMOD_A_TO_WR
                          || m_form == dmod_pkg::DMOD_DIR_TO_WR
                          || m_form == dmod_pkg::DMOD_IMM_TO_WR
                          || m_form == dmod_pkg::DMOD_WR_TO_DIR;     // see RULE_16
    wire logic uses_ind_nxt = m_form == dmod_pkg::DMOD_IND_TO_DIR
                           || m_form == dmod_pkg::DMOD_A_TO_IND
                           || m_form == dmod_pkg::DMOD_DIR_TO_IND
                           || m_form == dmod_pkg::DMOD_IMM_TO_IND
                           || m_form == dmod_pkg::DMOD_XRD_IND
                           || m_form == dmod_pkg::DMOD_IND_TO_A;     // see RULE_16
    wire logic [2:0] wr_nxt  = uses_wr_nxt ? opcode[2:0] : 3'h0;     // see RULE_16
    wire logic       ind_nxt = uses_ind_nxt & opcode[0];             // see RULE_16

    ////////////////////////////////////////////////////////////////////////////
    // Result registers, one cycle after the request
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dec_valid      <= 1'b0;
            dec_hit        <= 1'b0;
            dec_form       <= dmod_pkg::DMOD_NONE;
            dec_length     <= 2'h0;
            dec_cycles_min <= 4'h0;
            dec_cycles_max <= 4'h0;
            dec_external   <= 1'b0;
            dec_uses_wr    <= 1'b0;
            dec_work_reg   <= 3'h0;
            dec_uses_ind   <= 1'b0;
            dec_ind_reg    <= 1'b0;
        end
        else
        begin
            dec_valid <= op_valid;
            if (op_valid)
            begin
                dec_hit        <= hit_nxt;
                dec_form       <= m_form;
                dec_length     <= hit_nxt ? m_len : 2'h0;
                dec_cycles_min <= hit_nxt ? m_cyc : 4'h0;
                dec_cycles_max <= hit_nxt ? cmax_nxt : 4'h0;
                dec_external   <= m_ext;
                dec_uses_wr    <= uses_wr_nxt;
                dec_work_reg   <= wr_nxt;
                dec_uses_ind   <= uses_ind_nxt;
                dec_ind_reg    <= ind_nxt;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // Work register forms; the index must follow this opcode, not a stale one
    a_wr_a_form: assert property (op_valid && (opcode & 8'hF8) == 8'hF8 |=> // see RULE_01
        dec_form == dmod_pkg::DMOD_A_TO_WR && dec_length == 2'h1 && dec_cycles_min == 4'h1)
        else $error("F8-FF decode wrong");
    a_dir_to_wr: assert property (op_valid && (opcode & 8'hF8) == 8'hA8 |=> // see RULE_01
        dec_form == dmod_pkg::DMOD_DIR_TO_WR && dec_length == 2'h2 && dec_cycles_max == 4'h2)
        else $error("A8-AF decode wrong");
    a_imm_to_wr: assert property (op_valid && (opcode & 8'hF8) == 8'h78 |=> // see RULE_01
        dec_form == dmod_pkg::DMOD_IMM_TO_WR && dec_length == 2'h2 && dec_cycles_min == 4'h2)
        else $error("78-7F decode wrong");
    a_wr_dir_sel: assert property (op_valid && (opcode & 8'hF8) == 8'h88 |=> // see RULE_03
        dec_form == dmod_pkg::DMOD_WR_TO_DIR && dec_work_reg == $past(opcode[2:0]))
        else $error("88-8F decode wrong");
    a_wr_select: assert property (op_valid && (opcode[7:3] == 5'h1F // see RULE_16
        || opcode[7:3] == 5'h15 || opcode[7:3] == 5'h0F) |=>
        dec_uses_wr && !dec_uses_ind && dec_work_reg == $past(opcode[2:0]))
        else $error("work register index wrong");

    // Direct-byte destinations
    a_dir_store: assert property (op_valid && opcode == 8'hF5 |=> // see RULE_02
        dec_form == dmod_pkg::DMOD_A_TO_DIR && dec_length == 2'h2 && dec_cycles_max == 4'h2)
        else $error("F5 decode wrong");
    a_dir_dir_len: assert property (op_valid && opcode == 8'h85 |=> // see RULE_04
        dec_length == 2'h3 && dec_cycles_min == 4'h3)
        else $error("85 decode wrong");
    a_ind_to_dir: assert property (op_valid && (opcode & 8'hFE) == 8'h86 |=> // see RULE_05
        dec_form == dmod_pkg::DMOD_IND_TO_DIR && dec_length == 2'h2 && dec_cycles_min == 4'h2)
        else $error("86-87 decode wrong");
    a_imm_dir_len: assert property (op_valid && opcode == 8'h75 |=> // see RULE_06
        dec_form == dmod_pkg::DMOD_IMM_TO_DIR && dec_length == 2'h3 && dec_cycles_max == 4'h3)
        else $error("75 decode wrong");

    // Indirect memory forms
    a_acc_to_ind: assert property (op_valid && (opcode & 8'hFE) == 8'hF6 |=> // see RULE_07
        dec_form == dmod_pkg::DMOD_A_TO_IND && dec_length == 2'h1 && dec_cycles_max == 4'h1)
        else $error("F6-F7 decode wrong");
    a_dir_to_ind: assert property (op_valid && (opcode & 8'hFE) == 8'hA6 |=> // see RULE_08
        dec_form == dmod_pkg::DMOD_DIR_TO_IND && dec_length == 2'h2 && dec_cycles_min == 4'h2)
        else $error("A6-A7 decode wrong");
    a_imm_to_ind: assert property (op_valid && (opcode & 8'hFE) == 8'h76 |=> // see RULE_09
        dec_form == dmod_pkg::DMOD_IMM_TO_IND && dec_length == 2'h2 && dec_cycles_max == 4'h2)
        else $error("76-77 decode wrong");
    a_ind_select: assert property (op_valid && (opcode & 8'hFE) == 8'hE6 |=> // see RULE_15
        dec_uses_ind && dec_ind_reg == $past(opcode[0]) && dec_cycles_max == 4'h1)
        else $error("E6-E7 decode wrong");
    a_ind_index: assert property (op_valid && ((opcode & 8'hFE) == 8'hF6 // see RULE_16
        || (opcode & 8'hFE) == 8'hA6 || (opcode & 8'hFE) == 8'h76) |=>
        dec_uses_ind && !dec_uses_wr && dec_ind_reg == $past(opcode[0]))
        else $error("indirect register index wrong");

    // Data pointer, code memory and external forms
    // External cycle counts are only bounded; the bus wait states decide the rest
    a_imm_dp_len: assert property (op_valid && opcode == 8'h90 |=> // see RULE_10
        dec_form == dmod_pkg::DMOD_IMM_TO_DP && dec_length == 2'h3)
        else $error("90 decode wrong");
    a_code_cycles: assert property (op_valid && (opcode == 8'h93 || opcode == 8'h83) |=> // see RULE_11
        dec_length == 2'h1 && dec_cycles_max == 4'h3)
        else $error("code read decode wrong");
    a_code_pc_form: assert property (op_valid && opcode == 8'h83 |=> // see RULE_12
        dec_form == dmod_pkg::DMOD_CODE_PC && dec_cycles_min == 4'h3 && !dec_external)
        else $error("83 decode wrong");
    a_ext_range: assert property (op_valid && (opcode == 8'hE0 || opcode == 8'hF0 // see RULE_13
        || (opcode & 8'hFE) == 8'hE2) |=> dec_external && dec_cycles_min == 4'h2
        && dec_cycles_max == 4'h9)
        else $error("external decode wrong");
    a_xrd_ind_form: assert property (op_valid && (opcode & 8'hFE) == 8'hE2 |=> // see RULE_13
        dec_form == dmod_pkg::DMOD_XRD_IND && dec_uses_ind && dec_ind_reg == $past(opcode[0]))
        else $error("E2-E3 decode wrong");
    a_xrd_dp_form: assert property (op_valid && opcode == 8'hE0 |=> // see RULE_14
        dec_form == dmod_pkg::DMOD_XRD_DP && dec_length == 2'h1 && !dec_uses_ind)
        else $error("E0 decode wrong");
    a_xwr_dp_form: assert property (op_valid && opcode == 8'hF0 |=> // see RULE_17
        dec_form == dmod_pkg::DMOD_XWR_DP && dec_length == 2'h1 && !dec_uses_ind)
        else $error("F0 decode wrong");

    // Results move only on a taken request
    a_hold_idle: assert property (!op_valid |=> !dec_valid && $stable(dec_form)) // see RULE_16
        else $error("result changed without request");

    c_ext_read: cover property (dec_valid && dec_form == dmod_pkg::DMOD_XRD_DP);
    c_three_byte: cover property (dec_valid && dec_length == 2'h3);
    c_miss: cover property (dec_valid && !dec_hit);
    c_back_to_back: cover property (dec_valid [*3]);
    c_ind_high: cover property (dec_valid && dec_uses_ind && dec_ind_reg);

endmodule : dmod_decoder

// file: tb/dmod_fetch_model.sv
// Fetch-side model that presents opcodes to the data-move decoder
`timescale 1ns/1ps
module dmod_fetch_model
(
    // Clock
    input  wire logic       sys_clk,
    // Request to decoder
    output logic            op_valid,
    output logic [7:0]      opcode
);

    initial
    begin
        op_valid = 1'b0;
        opcode   = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Presents one opcode for the next edge; back to back calls keep valid up
    task automatic drive(input logic [7:0] op);
        @(posedge sys_clk);
        #1;
        op_valid = 1'b1;
        opcode   = op;
    endtask : drive

    // Released bus shows the inverse, so stale opcodes cannot look stable
    task automatic release_bus();
        @(posedge sys_clk);
        #1;
        op_valid = 1'b0;
        opcode   = ~opcode;
    endtask : release_bus

    // Idle byte keeps changing; checked late so it never races drive
    always @(posedge sys_clk)
    begin
        #3;
        if (!op_valid)
            opcode = opcode ^ 8'hA5;
    end

endmodule : dmod_fetch_model

// file: tb/tb.sv
// Self-checking testbench for the data-move opcode decoder
`timescale 1ns/1ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin errors++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp); end end
module tb;

    logic                 sys_clk;
    logic                 resetn;
    logic                 op_valid;
    logic [7:0]           opcode;
    logic                 dec_valid;
    logic                 dec_hit;
    dmod_pkg::dmod_form_t dec_form;
    logic [1:0]           dec_length;
    logic [3:0]           dec_cycles_min;
    logic [3:0]           dec_cycles_max;
    logic                 dec_external;
    logic                 dec_uses_wr;
    logic [2:0]           dec_work_reg;
    logic                 dec_uses_ind;
    logic                 dec_ind_reg;
    int                   errors;
    int                   cmp_count;
    logic [22:0]          got_vec;

    assign got_vec = {dec_hit, dec_form, dec_length, dec_cycles_min, dec_cycles_max,
                      dec_external, dec_uses_wr, dec_work_reg, dec_uses_ind, dec_ind_reg};

    dmod_fetch_model u_dmod_fetch_model (.sys_clk(sys_clk), .op_valid(op_valid),
                                         .opcode(opcode));

    dmod_decoder u_dmod_decoder (.sys_clk(sys_clk), .resetn(resetn), .op_valid(op_valid),
        .opcode(opcode), .dec_valid(dec_valid), .dec_hit(dec_hit), .dec_form(dec_form),
        .dec_length(dec_length), .dec_cycles_min(dec_cycles_min),
        .dec_cycles_max(dec_cycles_max), .dec_external(dec_external),
        .dec_uses_wr(dec_uses_wr), .dec_work_reg(dec_work_reg),
        .dec_uses_ind(dec_uses_ind), .dec_ind_reg(dec_ind_reg));

    initial
    begin
        sys_clk = 1'b0;
        resetn  = 1'b0;
    end

    always #10 sys_clk = ~sys_clk;

    ////////////////////////////////////////////////////////////////////////////
    // Expected decode: {form, length, base cycles, external, uses reg, uses ind}
    function automatic logic [22:0] expect_of(input logic [7:0] op);
        logic [13:0]          r;
        dmod_pkg::dmod_form_t f;
        logic [3:0]           mx;
        r = 14'h0000;
        casez (op)
            8'b1111_1???: r = {dmod_pkg::DMOD_A_TO_WR,    2'h1, 4'h1, 3'b010};
            8'b1010_1???: r = {dmod_pkg::DMOD_DIR_TO_WR,  2'h2, 4'h2, 3'b010};
            8'b0111_1???: r = {dmod_pkg::DMOD_IMM_TO_WR,  2'h2, 4'h2, 3'b010};
            8'b1111_0101: r = {dmod_pkg::DMOD_A_TO_DIR,   2'h2, 4'h2, 3'b000};
            8'b1000_1???: r = {dmod_pkg::DMOD_WR_TO_DIR,  2'h2, 4'h2, 3'b010};
            8'b1000_0101: r = {dmod_pkg::DMOD_DIR_TO_DIR, 2'h3, 4'h3, 3'b000};
            8'b1000_011?: r = {dmod_pkg::DMOD_IND_TO_DIR, 2'h2, 4'h2, 3'b001};
            8'b0111_0101: r = {dmod_pkg::DMOD_IMM_TO_DIR, 2'h3, 4'h3, 3'b000};
            8'b1111_011?: r = {dmod_pkg::DMOD_A_TO_IND,   2'h1, 4'h1, 3'b001};
            8'b1010_011?: r = {dmod_pkg::DMOD_DIR_TO_IND, 2'h2, 4'h2, 3'b001};
            8'b0111_011?: r = {dmod_pkg::DMOD_IMM_TO_IND, 2'h2, 4'h2, 3'b001};
            8'b1001_0000: r = {dmod_pkg::DMOD_IMM_TO_DP,  2'h3, 4'h3, 3'b000};
            8'b1001_0011: r = {dmod_pkg::DMOD_CODE_DP,    2'h1, 4'h3, 3'b000};
            8'b1000_0011: r = {dmod_pkg::DMOD_CODE_PC,    2'h1, 4'h3, 3'b000};
            8'b1110_001?: r = {dmod_pkg::DMOD_XRD_IND,    2'h1, 4'h2, 3'b101};
            8'b1110_0000: r = {dmod_pkg::DMOD_XRD_DP,     2'h1, 4'h2, 3'b100};
            8'b1110_011?: r = {dmod_pkg::DMOD_IND_TO_A,   2'h1, 4'h1, 3'b001};
            8'b1111_0000: r = {dmod_pkg::DMOD_XWR_DP,     2'h1, 4'h2, 3'b100};
            default:      r = 14'h0000;
        endcase
        f  = dmod_pkg::dmod_form_t'(r[13:9]);
        // External forms span the 2 to 9 cycle window
        mx = r[2] ? 4'h9 : r[6:3];
        return {f != dmod_pkg::DMOD_NONE, r[13:3], mx, r[2], r[1],
                r[1] ? op[2:0] : 3'h0, r[0], r[0] & op[0]};
    endfunction : expect_of

    task automatic check_out(input logic [7:0] op, input logic valid_exp);
        #1;
        `CHK(dec_valid, valid_exp)
        `CHK(got_vec, expect_of(op))
    endtask : check_out

    task automatic do_reset();
        resetn = 1'b0;
        #1;
        `CHK(dec_valid, 1'b0)
        `CHK(got_vec, 23'h000000)
        @(posedge sys_clk);
        #1;
        resetn = 1'b1;
        repeat (2) @(posedge sys_clk);
    endtask : do_reset

    ////////////////////////////////////////////////////////////////////////////
    // Every opcode, back to back, each checked while the next one is taken, FF after the bus is released
    task automatic test_sweep();
        u_dmod_fetch_model.drive(8'h00);
        for (int i = 1; i < 256; i++)
        begin
            u_dmod_fetch_model.drive(i[7:0]);
            check_out(i[7:0] - 8'h01, 1'b1);
        end
        u_dmod_fetch_model.release_bus();
        check_out(8'hFF, 1'b1);
    endtask : test_sweep

    // Outputs hold while the request line is idle and the opcode wanders
    task automatic test_hold(input logic [7:0] op);
        u_dmod_fetch_model.drive(op);
        u_dmod_fetch_model.release_bus();
        check_out(op, 1'b1);
        repeat (2)
        begin
            @(posedge sys_clk);
            check_out(op, 1'b0);
        end
    endtask : test_hold

    // Reset in mid-run clears the result at once, then decoding resumes
    task automatic test_mid_reset();
        test_hold(8'hE3);
        #5;
        do_reset();
        test_hold(8'hF0);
        test_hold(8'h93);
    endtask : test_mid_reset

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        errors    = 0;
        cmp_count = 0;
        repeat (2) @(posedge sys_clk);
        do_reset();
        test_sweep();
        test_hold(8'h85);
        test_mid_reset();
        print_verdict();
    end

    // Run needs about 300 cycles; this allows ample margin
    initial
    begin
        #100000;
        errors++;
        print_verdict();
    end

endmodule : tb
